// >>> rtl/ptm_timer_regs.svh
/*
  Register offsets, field positions and reset values of the periodic timer.
  Assumes a 3-bit word address and 16-bit register data on the plain port.
*/
`ifndef PTM_TIMER_REGS_SVH
`define PTM_TIMER_REGS_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define PTM_ADDR_CTRL          3'h0
`define PTM_ADDR_DUTY          3'h1
`define PTM_ADDR_PERIOD        3'h2
`define PTM_ADDR_COUNT         3'h3
`define PTM_ADDR_FLAGS         3'h4

// ------------------------------------------------------------
// Control field positions
// ------------------------------------------------------------
`define PTM_CTRL_MODE_LO       0
`define PTM_CTRL_MODE_HI       1
`define PTM_CTRL_OUT_LO        2
`define PTM_CTRL_OUT_HI        3
`define PTM_CTRL_RUN           4
`define PTM_CTRL_CLR_SRC       5
`define PTM_CTRL_INIT_LVL      6
`define PTM_CTRL_POL           7
`define PTM_CTRL_CAP_SRC       8
`define PTM_CTRL_PIN_SEL       9

// ------------------------------------------------------------
// Flag positions, reset values and output control and capture codes
// ------------------------------------------------------------
`define PTM_FLAG_DUTY          0
`define PTM_FLAG_PERIOD        1
`define PTM_DATA_RST           16'h0000
`define PTM_OUT_FORCE_OFF      2'h0
`define PTM_OUT_FORCE_ON       2'h1
`define PTM_OUT_PWM            2'h2
`define PTM_OUT_PULSE          2'h3
`define PTM_CAP_NONE           2'h3

// ------------------------------------------------------------
// Pin positions in the edge detector group
// ------------------------------------------------------------
`define PTM_PIN_A              0
`define PTM_PIN_B              1
`define PTM_PIN_EXT            2
`define PTM_PIN_CNT            3

`endif

// >>> rtl/ptm_pkg.sv
/*
  Types shared by the periodic timer files.
  Assumes nothing of its surroundings.
*/
package ptm_pkg;

  // Operating mode encoding of the mode select field
  typedef enum logic [1:0] {
    PTM_MODE_CMP = 2'h0,
    PTM_MODE_CAP = 2'h1,
    PTM_MODE_PWM = 2'h2,
    PTM_MODE_TMR = 2'h3
  } ptm_mode_e;

endpackage

// >>> rtl/ptm_edge_det.sv
/*
  Rising and falling edge detector for a group of pins.
  Assumes pins synchronous to core_clk; state frozen while ce is low.
*/
`timescale 1ns/1ps
module ptm_edge_det #(
  parameter int N = 3
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [N-1:0] pins,
  output logic      [N-1:0] rise,
  output logic      [N-1:0] fall
);

  logic [N-1:0] prev;

  generate
    if (N < 1)
    begin : g_chk
      $error("ptm_edge_det: N must be at least 1");
    end
    for (genvar i = 0; i < N; i++)
    begin : g_pin
      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
          prev[i] <= 1'b0;
        else if (ce)
          prev[i] <= pins[i];
      end
      assign rise[i] = pins[i] & ~prev[i];
      assign fall[i] = ~pins[i] & prev[i];
    end
  endgenerate

endmodule

// >>> rtl/ptm_timer.sv
/*
  Periodic timer: edge-aligned PWM, single pulse and input capture.
  Assumes synchronous pins, a plain register port with one-cycle strobes,
  and a single clock core_clk with asynchronous active-low reset.
*/
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "ptm_timer_regs.svh"
module ptm_timer
  import ptm_pkg::*;
#(
  parameter int CNT_W = 10
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic [2:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  input  wire logic        timer_pin_a,
  input  wire logic        timer_pin_b,
  input  wire logic        ext_clock_pin,
  output logic             timer_out,
  output logic             duty_flag,
  output logic             period_flag
);

  // ------------------------------------------------------------
  // Parameter check
  // ------------------------------------------------------------
  generate
    if (CNT_W < 2 || CNT_W > 16)
    begin : g_chk
      $error("ptm_timer: CNT_W must be 2 to 16");
    end
  endgenerate

  // ------------------------------------------------------------
  // Control state
  // ------------------------------------------------------------
  ptm_mode_e          mode_select;
  logic [1:0]         output_ctrl;
  logic               counter_run;
  logic               run_q;
  logic               clear_source_select;
  logic               initial_output_level;
  logic               output_polarity;
  logic               capture_source_select;
  logic               timer_pin_select;
  logic [CNT_W-1:0]   duty_compare;
  logic [CNT_W-1:0]   period_compare;
  logic [CNT_W-1:0]   count;

  logic               wr_ctrl;
  logic               wr_duty;
  logic               wr_flags;
  logic               is_pwm;
  logic               is_single;
  logic               is_cap;
  logic               counting;
  logic               run_rise;
  logic [CNT_W-1:0]   last_count;
  logic               period_hit;
  logic               duty_hit;
  logic               duty_full;
  logic               pwm_level;
  logic               act_pin;
  logic               inact_pin;
  logic               trig;
  logic               cap_hit;
  logic               cap_rise;
  logic               cap_fall;
  logic               next_pin;
  logic [2:0]         pin_rise;
  logic [2:0]         pin_fall;

  // Selects the active capture edge from output control
  function automatic logic edge_match(input logic [1:0] sel, input logic r, input logic f);
    unique case (sel)
      2'h0: edge_match = r;
      2'h1: edge_match = f;
      2'h2: edge_match = r | f;
      2'h3: edge_match = 1'b0;
    endcase
  endfunction

  assign wr_ctrl  = wr && (addr == `PTM_ADDR_CTRL);
  assign wr_duty  = wr && (addr == `PTM_ADDR_DUTY);
  assign wr_flags = wr && (addr == `PTM_ADDR_FLAGS);

  // ------------------------------------------------------------
  // Mode decode and compare
  // ------------------------------------------------------------
  assign is_pwm     = (mode_select == PTM_MODE_PWM) && (output_ctrl != `PTM_OUT_PULSE);
  assign is_single  = (mode_select == PTM_MODE_PWM) && (output_ctrl == `PTM_OUT_PULSE);
  assign is_cap     = (mode_select == PTM_MODE_CAP);
  assign run_rise   = counter_run && !run_q;
  assign counting   = counter_run && run_q;
  // Zero period wraps to all ones, giving the full counter range
  assign last_count = period_compare - CNT_W'(1);
  assign period_hit = counting && !is_single && (count == last_count);
  assign duty_hit   = counting && (is_single || is_pwm) && (count == duty_compare);
  assign duty_full  = (period_compare != '0) && (duty_compare >= period_compare);
  assign pwm_level  = counting && (duty_full || (count < duty_compare));
  assign act_pin    = initial_output_level ^ output_polarity;
  assign inact_pin  = ~initial_output_level ^ output_polarity;
  assign trig       = is_single && !counter_run && pin_rise[`PTM_PIN_EXT];
  assign cap_rise   = capture_source_select ? pin_rise[`PTM_PIN_EXT] :
                      (timer_pin_select ? pin_rise[`PTM_PIN_B] : pin_rise[`PTM_PIN_A]);
  assign cap_fall   = capture_source_select ? pin_fall[`PTM_PIN_EXT] :
                      (timer_pin_select ? pin_fall[`PTM_PIN_B] : pin_fall[`PTM_PIN_A]);
  // Pins are watched whatever their shared direction
  assign cap_hit    = is_cap && counting && edge_match(output_ctrl, cap_rise, cap_fall);

  ptm_edge_det #(
    .N        (`PTM_PIN_CNT)
  ) u_edge (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .pins     ({ext_clock_pin, timer_pin_b, timer_pin_a}),
    .rise     (pin_rise),
    .fall     (pin_fall)
  );

  // ------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_select           <= PTM_MODE_CMP;
      output_ctrl           <= 2'h0;
      clear_source_select   <= 1'b0;
      initial_output_level  <= 1'b0;
      output_polarity       <= 1'b0;
      capture_source_select <= 1'b0;
      timer_pin_select      <= 1'b0;
    end
    else if (ce && wr_ctrl)
    begin
      mode_select           <= ptm_mode_e'(wdata[`PTM_CTRL_MODE_HI:`PTM_CTRL_MODE_LO]);
      output_ctrl           <= wdata[`PTM_CTRL_OUT_HI:`PTM_CTRL_OUT_LO];
      clear_source_select   <= wdata[`PTM_CTRL_CLR_SRC];
      initial_output_level  <= wdata[`PTM_CTRL_INIT_LVL];
      output_polarity       <= wdata[`PTM_CTRL_POL];
      capture_source_select <= wdata[`PTM_CTRL_CAP_SRC];
      timer_pin_select      <= wdata[`PTM_CTRL_PIN_SEL];
    end
  end

  // Run bit: hardware set wins over match clear and software write
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      counter_run <= 1'b0;
      run_q       <= 1'b0;
    end
    else if (ce)
    begin
      run_q <= counter_run;
      if (trig)
        counter_run <= 1'b1;
      else if (is_single && duty_hit)
        counter_run <= 1'b0;
      else if (wr_ctrl)
        counter_run <= wdata[`PTM_CTRL_RUN];
    end
  end

  // ------------------------------------------------------------
  // Compare registers
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      duty_compare <= '0;
    else if (ce)
    begin
      if (cap_hit)
        duty_compare <= count;
      else if (wr_duty)
        duty_compare <= wdata[CNT_W-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      period_compare <= '0;
    else if (ce && wr && (addr == `PTM_ADDR_PERIOD))
      period_compare <= wdata[CNT_W-1:0];
  end

  // ------------------------------------------------------------
  // Counter
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      count <= '0;
    else if (ce)
    begin
      if (run_rise)
        count <= '0;
      else if (period_hit)
        count <= '0;
      else if (counting)
        count <= count + CNT_W'(1);
    end
  end

  // ------------------------------------------------------------
  // Flags, set wins over write-one clear
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      duty_flag <= 1'b0;
    else if (ce)
    begin
      if (duty_hit || cap_hit)
        duty_flag <= 1'b1;
      else if (wr_flags && wdata[`PTM_FLAG_DUTY])
        duty_flag <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      period_flag <= 1'b0;
    else if (ce)
    begin
      if (period_hit)
        period_flag <= 1'b1;
      else if (wr_flags && wdata[`PTM_FLAG_PERIOD])
        period_flag <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Output pin
  // ------------------------------------------------------------
  always_comb
  begin
    next_pin = 1'b0;
    if (mode_select == PTM_MODE_PWM)
    begin
      unique case (output_ctrl)
        `PTM_OUT_FORCE_OFF: next_pin = inact_pin;
        `PTM_OUT_FORCE_ON:  next_pin = act_pin;
        `PTM_OUT_PWM:       next_pin = pwm_level ? act_pin : inact_pin;
        `PTM_OUT_PULSE:     next_pin = counter_run ? act_pin : inact_pin;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      timer_out <= 1'b0;
    else if (ce)
      timer_out <= next_pin;
  end

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= `PTM_DATA_RST;
    else if (ce)
    begin
      rdata <= `PTM_DATA_RST;
      if (rd)
      begin
        unique case (addr)
          `PTM_ADDR_CTRL:
          begin
            rdata[`PTM_CTRL_MODE_HI:`PTM_CTRL_MODE_LO] <= mode_select;
            rdata[`PTM_CTRL_OUT_HI:`PTM_CTRL_OUT_LO]   <= output_ctrl;
            rdata[`PTM_CTRL_RUN]                       <= counter_run;
            rdata[`PTM_CTRL_CLR_SRC]                   <= clear_source_select;
            rdata[`PTM_CTRL_INIT_LVL]                  <= initial_output_level;
            rdata[`PTM_CTRL_POL]                       <= output_polarity;
            rdata[`PTM_CTRL_CAP_SRC]                   <= capture_source_select;
            rdata[`PTM_CTRL_PIN_SEL]                   <= timer_pin_select;
          end
          `PTM_ADDR_DUTY:   rdata <= 16'(duty_compare);
          `PTM_ADDR_PERIOD: rdata <= 16'(period_compare);
          `PTM_ADDR_COUNT:  rdata <= 16'(count);
          `PTM_ADDR_FLAGS:
          begin
            rdata[`PTM_FLAG_DUTY]   <= duty_flag;
            rdata[`PTM_FLAG_PERIOD] <= period_flag;
          end
          default:          rdata <= `PTM_DATA_RST;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  AST_PERIOD_WRAP: assert property (@(posedge core_clk) disable iff (!rst_n)
    ce && period_hit && !run_rise |=> count == '0)
    else $error("counter did not clear on period match");

  AST_FULL_DUTY: assert property (@(posedge core_clk) disable iff (!rst_n)
    ce && counting && output_ctrl == `PTM_OUT_PWM && mode_select == PTM_MODE_PWM && duty_full
    |=> timer_out == $past(act_pin))
    else $error("full duty did not hold active level");

  AST_FORCED_COUNT: assert property (@(posedge core_clk) disable iff (!rst_n)
    ce && is_pwm && output_ctrl != `PTM_OUT_PWM && counting && !period_hit
    |=> count == $past(count) + CNT_W'(1))
    else $error("counter stalled while output forced");

  AST_PULSE_START: assert property (@(posedge core_clk) disable iff (!rst_n)
    ce && is_single && run_rise |=> count == '0 && timer_out == $past(act_pin))
    else $error("pulse did not start on run rise");

  AST_EXT_TRIGGER: assert property (@(posedge core_clk) disable iff (!rst_n)
    ce && trig |=> counter_run ##1 (!$past(ce) || run_q))
    else $error("external edge did not set run bit");

  AST_PULSE_END: assert property (@(posedge core_clk) disable iff (!rst_n)
    ce && is_single && duty_hit && !trig |=> !counter_run && duty_flag)
    else $error("duty match did not end pulse");

  AST_CAPTURE: assert property (@(posedge core_clk) disable iff (!rst_n)
    ce && cap_hit |=> duty_compare == $past(count) && duty_flag)
    else $error("capture did not latch counter");

  AST_NO_CAPTURE: assert property (@(posedge core_clk) disable iff (!rst_n)
    ce && is_cap && output_ctrl == `PTM_CAP_NONE && !wr_duty |=> $stable(duty_compare))
    else $error("capture occurred with edges disabled");

  AST_CAP_PERIOD: assert property (@(posedge core_clk) disable iff (!rst_n)
    ce && is_cap && period_hit |=> period_flag && count == '0)
    else $error("capture period match missed");

  AST_FREEZE: assert property (@(posedge core_clk) disable iff (!rst_n)
    !ce |=> $stable(count) && $stable(timer_out) && $stable(counter_run))
    else $error("state changed with clock enable low");

endmodule

// >>> verification/ptm_pin_model.sv
/*
  Far-side pin driver for the capture and trigger pins of the timer.
  Assumes core_clk from the bench; pins change just after a rising edge.
*/
`timescale 1ns/1ps
module ptm_pin_model (
  input  wire logic core_clk,
  output logic      timer_pin_a,
  output logic      timer_pin_b,
  output logic      ext_clock_pin
);
  // ----------------------------------------
  // Pin levels
  // ----------------------------------------
  logic [2:0] lvl = 3'h0;

  assign timer_pin_a   = lvl[0];
  assign timer_pin_b   = lvl[1];
  assign ext_clock_pin = lvl[2];

  // Level held until the next call
  task automatic drive(input int idx, input logic level);
    @(posedge core_clk);
    lvl[idx] <= level;
  endtask
endmodule

// >>> verification/ptm_timer_tb.sv
/*
  Self-checking bench for the periodic timer: PWM, single pulse, capture.
  Assumes the design files and the pin model are compiled before it.
*/
`timescale 1ns/1ps
`include "ptm_timer_regs.svh"
module ptm_timer_tb
  import ptm_pkg::*;
;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic        core_clk    = 1'b0;
  logic        rst_n       = 1'b0;
  logic        ce          = 1'b1;
  logic [2:0]  addr        = 3'h0;
  logic [15:0] wdata       = 16'h0000;
  logic        wr          = 1'b0;
  logic        rd          = 1'b0;
  logic [15:0] rdata;
  logic        pin_a;
  logic        pin_b;
  logic        pin_x;
  logic        timer_out;
  logic        duty_flag;
  logic        period_flag;
  int          failures    = 0;
  int          checks_done = 0;

  ptm_timer uut (.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .timer_pin_a(pin_a), .timer_pin_b(pin_b), .ext_clock_pin(pin_x),
    .timer_out(timer_out), .duty_flag(duty_flag), .period_flag(period_flag));

  ptm_pin_model pins (.core_clk(core_clk), .timer_pin_a(pin_a), .timer_pin_b(pin_b), .ext_clock_pin(pin_x));

  initial
  begin
    forever #20 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    @(posedge core_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge core_clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
    @(posedge core_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge core_clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask

  function automatic logic [15:0] cw(input ptm_mode_e m, input logic [1:0] o, input logic run,
                                     input logic [4:0] hi);
    cw = {6'h00, hi, run, o, m};
  endfunction

  task automatic meas(input int n, output int h);
    h = 0;
    repeat (n)
    begin
      @(posedge core_clk);
      #1;
      if (timer_out === 1'b1)
        h++;
    end
  endtask

  task automatic seg(input logic [15:0] c, input logic [15:0] du, input int n, input int exp, input string w);
    int h;
    wr_reg(`PTM_ADDR_DUTY, du);
    wr_reg(`PTM_ADDR_CTRL, c);
    repeat (3) @(posedge core_clk);
    meas(n, h);
    chk(16'(h), 16'(exp), w);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [15:0] d;
    for (int a = 0; a < 6; a++)
    begin
      rd_reg(3'(a), d);
      chk(d, `PTM_DATA_RST, "reset or unmapped read");
    end
    chk({13'h0, timer_out, duty_flag, period_flag}, 16'h0000, "outputs after reset");
  endtask

  task automatic t_pwm();
    logic [15:0] c1;
    logic [15:0] c2;
    wr_reg(`PTM_ADDR_PERIOD, 16'h0008);
    seg(cw(PTM_MODE_PWM, `PTM_OUT_PWM, 1'b1, 5'h03), 16'h0003, 32, 12, "pwm duty");
    chk({14'h0, duty_flag, period_flag}, 16'h0003, "pwm flags");
    seg(cw(PTM_MODE_PWM, `PTM_OUT_PWM, 1'b1, 5'h07), 16'h0003, 32, 20, "pwm inverted");
    seg(cw(PTM_MODE_PWM, `PTM_OUT_PWM, 1'b1, 5'h03), 16'h0009, 32, 32, "pwm full duty");
    seg(cw(PTM_MODE_PWM, `PTM_OUT_FORCE_OFF, 1'b1, 5'h03), 16'h0009, 32, 0, "forced off");
    rd_reg(`PTM_ADDR_COUNT, c1);
    rd_reg(`PTM_ADDR_COUNT, c2);
    chk((c2 - c1) & 16'h0007, 16'h0002, "count while forced");
    seg(cw(PTM_MODE_PWM, `PTM_OUT_FORCE_ON, 1'b1, 5'h03), 16'h0009, 32, 32, "forced on");
    wr_reg(`PTM_ADDR_CTRL, 16'h0000);
    wr_reg(`PTM_ADDR_PERIOD, 16'h0000);
    seg(cw(PTM_MODE_PWM, `PTM_OUT_PWM, 1'b1, 5'h03), 16'h0200, 1024, 512, "pwm 1024 period");
  endtask

  task automatic t_pulse();
    int h1;
    int h2;
    logic [15:0] d;
    wr_reg(`PTM_ADDR_CTRL, 16'h0000);
    wr_reg(`PTM_ADDR_FLAGS, 16'h0003);
    #1;
    chk({14'h0, duty_flag, period_flag}, 16'h0000, "flags cleared");
    wr_reg(`PTM_ADDR_PERIOD, 16'h0002);
    wr_reg(`PTM_ADDR_DUTY, 16'h0005);
    wr_reg(`PTM_ADDR_CTRL, cw(PTM_MODE_PWM, `PTM_OUT_PULSE, 1'b0, 5'h02));
    wr_reg(`PTM_ADDR_CTRL, cw(PTM_MODE_PWM, `PTM_OUT_PULSE, 1'b1, 5'h02));
    meas(40, h1);
    chk(16'(h1 inside {[6:7]}), 16'h0001, "software pulse width");
    chk({15'h0, duty_flag}, 16'h0001, "pulse match flag");
    rd_reg(`PTM_ADDR_CTRL, d);
    chk({15'h0, d[`PTM_CTRL_RUN]}, 16'h0000, "run cleared by match");
    wr_reg(`PTM_ADDR_DUTY, 16'h0009);
    fork
      begin
        pins.drive(2, 1'b1);
        pins.drive(2, 1'b0);
      end
      meas(40, h2);
    join
    chk(16'(h2 - h1), 16'h0004, "triggered pulse width");
    wr_reg(`PTM_ADDR_DUTY, 16'h0014);
    fork
      begin
        wr_reg(`PTM_ADDR_CTRL, cw(PTM_MODE_PWM, `PTM_OUT_PULSE, 1'b1, 5'h02));
        wr_reg(`PTM_ADDR_CTRL, cw(PTM_MODE_PWM, `PTM_OUT_PULSE, 1'b0, 5'h02));
      end
      meas(40, h1);
    join
    chk(16'(h1 inside {[1:6]}), 16'h0001, "software stopped pulse");
  endtask

  task automatic t_capture();
    logic [15:0] d1;
    logic [15:0] d2;
    time         t1;
    wr_reg(`PTM_ADDR_CTRL, 16'h0000);
    wr_reg(`PTM_ADDR_PERIOD, 16'h0000);
    for (int m = 0; m < 4; m++)
    begin
      wr_reg(`PTM_ADDR_CTRL, cw(PTM_MODE_CAP, 2'(m), 1'b1, 5'h07));
      wr_reg(`PTM_ADDR_FLAGS, 16'h0003);
      pins.drive(0, 1'b1);
      t1 = $time;
      repeat (4) @(posedge core_clk);
      chk({15'h0, duty_flag}, 16'(m == 0 || m == 2), "rise capture");
      rd_reg(`PTM_ADDR_DUTY, d1);
      wr_reg(`PTM_ADDR_FLAGS, 16'h0003);
      pins.drive(0, 1'b0);
      t1 = $time - t1;
      repeat (4) @(posedge core_clk);
      chk({15'h0, duty_flag}, 16'(m == 1 || m == 2), "fall capture");
      rd_reg(`PTM_ADDR_DUTY, d2);
      if (m == 2)
        chk((d2 - d1) & 16'h03ff, 16'(t1 / 40), "captured interval");
      chk({15'h0, timer_out}, 16'h0000, "no output in capture");
    end
    for (int s = 0; s < 2; s++)
    begin
      wr_reg(`PTM_ADDR_CTRL, cw(PTM_MODE_CAP, 2'h0, 1'b1, (s == 1) ? 5'h08 : 5'h10));
      wr_reg(`PTM_ADDR_FLAGS, 16'h0003);
      pins.drive(0, 1'b1);
      repeat (4) @(posedge core_clk);
      chk({15'h0, duty_flag}, 16'h0000, "unselected pin");
      pins.drive(s + 1, 1'b1);
      repeat (4) @(posedge core_clk);
      chk({15'h0, duty_flag}, 16'h0001, "selected pin");
      pins.drive(0, 1'b0);
      pins.drive(s + 1, 1'b0);
    end
    // Restart so the count starts below the new period
    wr_reg(`PTM_ADDR_CTRL, cw(PTM_MODE_CAP, 2'h0, 1'b0, 5'h07));
    wr_reg(`PTM_ADDR_PERIOD, 16'h0006);
    wr_reg(`PTM_ADDR_CTRL, cw(PTM_MODE_CAP, 2'h0, 1'b1, 5'h07));
    wr_reg(`PTM_ADDR_FLAGS, 16'h0003);
    repeat (10) @(posedge core_clk);
    chk({15'h0, period_flag}, 16'h0001, "capture period flag");
    rd_reg(`PTM_ADDR_COUNT, d1);
    chk(16'(d1 < 16'h0006), 16'h0001, "capture count bound");
  endtask

  // Counter in period 6: three enabled edges between reads, five frozen
  task automatic t_freeze();
    logic [15:0] c1;
    logic [15:0] c2;
    rd_reg(`PTM_ADDR_COUNT, c1);
    @(posedge core_clk);
    ce <= 1'b0;
    repeat (5) @(posedge core_clk);
    ce <= 1'b1;
    rd_reg(`PTM_ADDR_COUNT, c2);
    chk((c2 + 16'h0006 - c1) % 16'h0006, 16'h0003, "count frozen while ce low");
  endtask

  // ----------------------------------------
  // Sequence, watchdog and verdict
  // ----------------------------------------
  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_pwm();
    t_pulse();
    t_capture();
    t_freeze();
    report_and_stop();
  end

  initial
  begin
    repeat (20000) @(posedge core_clk);
    failures++;
    report_and_stop();
  end
endmodule
